/* File: include/amp_ctrl_defs.vh */
`ifndef AMP_CTRL_DEFS_VH
`define AMP_CTRL_DEFS_VH

// register offsets on the control port
`define OFS_PAGE_SELECT 8'h00
`define OFS_BOOK_SELECT 8'h7f
`define OFS_CORE_RESET 8'h01
`define OFS_OUTPUT_CFG 8'h02
`define OFS_POWER_MUTE 8'h03

// book and page that hold the core control set
`define CORE_BOOK 8'h00
`define CORE_PAGE 8'h00

// reset values
`define RST_PAGE_SELECT 8'h00
`define RST_BOOK_SELECT 8'h00
`define RST_CORE_RESET 8'h00
`define RST_OUTPUT_CFG 8'h00
`define RST_POWER_MUTE 8'h10

// core_reset_strobes fields
`define BIT_FULL_CORE_RESET 4
`define BIT_REG_RESET 0

// output_stage_config fields
`define FSW_MSB 6
`define FSW_LSB 4
`define BIT_PARALLEL_BRIDGE 2
`define MOD_MSB 1
`define MOD_LSB 0
`define FSW_FIRST_RESERVED 3'h6
`define MOD_RESERVED 2'h3

// power_state_and_mute fields
`define BIT_DSP_HOLD 4
`define BIT_SOFT_MUTE 3
`define PS_MSB 1
`define PS_LSB 0
`define POWER_MUTE_WMASK 8'h1b

// power states
`define PS_DEEP_SLEEP 2'h0
`define PS_SLEEP 2'h1
`define PS_HIZ 2'h2
`define PS_PLAY 2'h3

// volume ramp timing
`define CLK_PERIOD_NS 50
`define RAMP_STEP_NS 1000
`define RAMP_STEP_CYCLES ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VOL_FULL 8'hff
`define VOL_ZERO 8'h00

// default bus address of the control port
`define DEFAULT_BUS_ADDR 7'h58

`endif

/* File: hdl/i2c_target_port.v */
`timescale 1ns/10ps
`default_nettype none
`include "amp_ctrl_defs.vh"

module i2c_target_port #(
  parameter [6:0] BUS_ADDR = `DEFAULT_BUS_ADDR
) (
  input wire clk,
  input wire rst_n,
  input wire scl,
  input wire sda_in,
  output reg sda_oe,
  output reg wr_stb,
  output reg wr_first,
  output reg [7:0] wr_byte,
  output reg rd_next,
  input wire [7:0] rd_data
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ADDR_ACK = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_WRITE_ACK = 3'h4;
  localparam [2:0] ST_READ = 3'h5;
  localparam [2:0] ST_READ_ACK = 3'h6;

  reg [2:0] state;
  reg scl_q;
  reg sda_q;
  reg [2:0] bit_cnt;
  reg byte_done;
  reg [7:0] shift;
  reg [7:0] tx;
  reg read_dir;
  reg first_pending;
  reg master_ack;

  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda_in;
  wire stop_seen = scl & scl_q & ~sda_q & sda_in;

  // protocol engine: start/stop, address, byte shift, acknowledge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      shift <= 8'h00;
      tx <= 8'h00;
      read_dir <= 1'b0;
      first_pending <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_first <= 1'b0;
      wr_byte <= 8'h00;
      rd_next <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      wr_stb <= 1'b0;
      rd_next <= 1'b0;
      if (start_seen) begin
        state <= ST_ADDR;
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 3'h1;
              byte_done <= (bit_cnt == 3'h7);
            end else if (scl_fall && byte_done) begin
              byte_done <= 1'b0;
              if (state == ST_ADDR) begin
                if (shift[7:1] == BUS_ADDR) begin
                  read_dir <= shift[0];
                  first_pending <= ~shift[0];
                  sda_oe <= 1'b1; // acknowledge address
                  state <= ST_ADDR_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                wr_stb <= 1'b1;
                wr_first <= first_pending;
                wr_byte <= shift;
                first_pending <= 1'b0;
                sda_oe <= 1'b1; // acknowledge data
                state <= ST_WRITE_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (read_dir) begin
                tx <= rd_data;
                rd_next <= 1'b1;
                sda_oe <= ~rd_data[7];
                state <= ST_READ;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_WRITE;
              end
            end
          end
          ST_WRITE_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt <= 3'h0;
              state <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt == 3'h7) begin
                sda_oe <= 1'b0; // let master acknowledge
                state <= ST_READ_ACK;
              end else begin
                tx <= {tx[6:0], 1'b0};
                sda_oe <= ~tx[6];
                bit_cnt <= bit_cnt + 3'h1;
              end
            end
          end
          ST_READ_ACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_in;
            end else if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (master_ack) begin
                tx <= rd_data;
                rd_next <= 1'b1;
                sda_oe <= ~rd_data[7];
                state <= ST_READ;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdl/amp_core_control_regs.v */
`timescale 1ns/10ps
`default_nettype none
`include "amp_ctrl_defs.vh"

module amp_core_control_regs #(
  parameter [6:0] BUS_ADDR = `DEFAULT_BUS_ADDR,
  parameter integer RAMP_STEP_CYCLES = `RAMP_STEP_CYCLES
) (
  input wire CLK,
  input wire RST_N,
  input wire SCL,
  input wire SDA_IN,
  output reg SDA_OUT,
  output wire SDA_OE,
  output wire [2:0] SWITCHING_FREQ_SELECT,
  output wire PARALLEL_BRIDGE_SELECT,
  output wire [1:0] MODULATION_SCHEME,
  output reg DSP_HOLD_IN_RESET,
  output wire SOFT_MUTE_REQ,
  output reg [1:0] POWER_STATE,
  output reg [7:0] VOLUME_SCALE,
  output reg DIGITAL_CORE_RESET,
  output reg COEF_RAM_CLEAR
);

  reg [7:0] page_select;
  reg [7:0] book_select;
  reg [7:0] output_stage_config;
  reg [7:0] power_state_and_mute;
  reg [7:0] reg_ptr;
  reg [15:0] ramp_cnt;
  wire wr_stb;
  wire wr_first;
  wire [7:0] wr_byte;
  wire rd_next;
  reg [7:0] rd_data;
  wire core_page;
  wire full_reset_req;
  wire reg_reset_req;
  reg [7:0] next_output_stage_config;
  wire [7:0] next_power_state_and_mute;
  wire target_mute;
  wire ramp_tick;
  wire [1:0] cmd_state;

  // true when the selected book and page hold this register set
  function in_core_page;
    input [7:0] book;
    input [7:0] page;
    begin
      in_core_page = (book == `CORE_BOOK) && (page == `CORE_PAGE);
    end
  endfunction

  // true when an offset is one of the mapped locations of the current page
  function is_mapped;
    input [7:0] ofs;
    input [7:0] book;
    input [7:0] page;
    begin
      is_mapped = (ofs == `OFS_PAGE_SELECT)
        || ((ofs == `OFS_BOOK_SELECT) && (page == `CORE_PAGE))
        || (in_core_page(book, page) && ((ofs == `OFS_CORE_RESET)
          || (ofs == `OFS_OUTPUT_CFG) || (ofs == `OFS_POWER_MUTE)));
    end
  endfunction

  // serial control port
  i2c_target_port #(
    .BUS_ADDR(BUS_ADDR)
  ) u_port (
    .clk(CLK),
    .rst_n(RST_N),
    .scl(SCL),
    .sda_in(SDA_IN),
    .sda_oe(SDA_OE),
    .wr_stb(wr_stb),
    .wr_first(wr_first),
    .wr_byte(wr_byte),
    .rd_next(rd_next),
    .rd_data(rd_data)
  );

  // open-drain data line only ever pulls low
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end

  assign core_page = in_core_page(book_select, page_select);

  // true when the pointer names a core register and book zero, page zero is selected
  function hits_core;
    input [7:0] ptr;
    input [7:0] ofs;
    input in_page;
    begin
      hits_core = in_page && (ptr == ofs);
    end
  endfunction

  // data writes land on the pointer; the first byte only moves it
  wire data_wr = wr_stb & ~wr_first;
  wire reset_wr = data_wr & hits_core(reg_ptr, `OFS_CORE_RESET, core_page);
  wire cfg_wr = data_wr & hits_core(reg_ptr, `OFS_OUTPUT_CFG, core_page);
  wire power_wr = data_wr & hits_core(reg_ptr, `OFS_POWER_MUTE, core_page);
  wire page_wr = data_wr & (reg_ptr == `OFS_PAGE_SELECT);
  wire book_wr = data_wr & (reg_ptr == `OFS_BOOK_SELECT) & (page_select == `CORE_PAGE);

  // strobe bits act on the write itself and are never stored
  assign full_reset_req = reset_wr & wr_byte[`BIT_FULL_CORE_RESET];
  assign reg_reset_req = reset_wr & wr_byte[`BIT_REG_RESET];
  wire any_reset_req = full_reset_req | reg_reset_req;

  // config field update; a reserved code keeps the previous setting
  always @* begin
    next_output_stage_config = 8'h00;
    next_output_stage_config[`FSW_MSB:`FSW_LSB] = wr_byte[`FSW_MSB:`FSW_LSB];
    if (wr_byte[`FSW_MSB:`FSW_LSB] >= `FSW_FIRST_RESERVED) begin
      next_output_stage_config[`FSW_MSB:`FSW_LSB] = output_stage_config[`FSW_MSB:`FSW_LSB];
    end
    next_output_stage_config[`BIT_PARALLEL_BRIDGE] = wr_byte[`BIT_PARALLEL_BRIDGE];
    next_output_stage_config[`MOD_MSB:`MOD_LSB] = wr_byte[`MOD_MSB:`MOD_LSB];
    if (wr_byte[`MOD_MSB:`MOD_LSB] == `MOD_RESERVED) begin
      next_output_stage_config[`MOD_MSB:`MOD_LSB] = output_stage_config[`MOD_MSB:`MOD_LSB];
    end
  end

  // only dsp hold, mute and state bits are writable
  assign next_power_state_and_mute = wr_byte & `POWER_MUTE_WMASK;

  // page select, reachable from every book and page
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      page_select <= `RST_PAGE_SELECT;
    end else if (any_reset_req) begin
      page_select <= `RST_PAGE_SELECT;
    end else if (page_wr) begin
      page_select <= wr_byte;
    end
  end

  // book select, only while page zero is selected
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      book_select <= `RST_BOOK_SELECT;
    end else if (any_reset_req) begin
      book_select <= `RST_BOOK_SELECT;
    end else if (book_wr) begin
      book_select <= wr_byte;
    end
  end

  // output stage configuration
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      output_stage_config <= `RST_OUTPUT_CFG;
    end else if (any_reset_req) begin
      output_stage_config <= `RST_OUTPUT_CFG;
    end else if (cfg_wr) begin
      output_stage_config <= next_output_stage_config;
    end
  end

  // dsp hold, mute and commanded power state
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      power_state_and_mute <= `RST_POWER_MUTE;
    end else if (any_reset_req) begin
      power_state_and_mute <= `RST_POWER_MUTE;
    end else if (power_wr) begin
      power_state_and_mute <= next_power_state_and_mute;
    end
  end

  // pointer: first byte loads it, each data byte or read byte advances it
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      reg_ptr <= 8'h00;
    end else if (wr_stb && wr_first) begin
      reg_ptr <= wr_byte;
    end else if (wr_stb || rd_next) begin
      reg_ptr <= reg_ptr + 8'h01;
    end
  end

  // read mux; strobes and unmapped offsets return zero
  always @* begin
    rd_data = 8'h00;
    if (!is_mapped(reg_ptr, book_select, page_select)) begin
      rd_data = 8'h00;
    end else if (reg_ptr == `OFS_PAGE_SELECT) begin
      rd_data = page_select;
    end else if (reg_ptr == `OFS_BOOK_SELECT) begin
      rd_data = book_select;
    end else if (reg_ptr == `OFS_CORE_RESET) begin
      rd_data = `RST_CORE_RESET;
    end else if (reg_ptr == `OFS_OUTPUT_CFG) begin
      rd_data = output_stage_config;
    end else if (reg_ptr == `OFS_POWER_MUTE) begin
      rd_data = power_state_and_mute;
    end
  end

  // one-cycle pulses to the digital core and coefficient memory
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DIGITAL_CORE_RESET <= 1'b0;
      COEF_RAM_CLEAR <= 1'b0;
    end else begin
      DIGITAL_CORE_RESET <= full_reset_req;
      COEF_RAM_CLEAR <= full_reset_req;
    end
  end

  // configuration fields drive the output stage directly
  assign SWITCHING_FREQ_SELECT = output_stage_config[`FSW_MSB:`FSW_LSB];
  assign PARALLEL_BRIDGE_SELECT = output_stage_config[`BIT_PARALLEL_BRIDGE];
  assign MODULATION_SCHEME = output_stage_config[`MOD_MSB:`MOD_LSB];
  assign SOFT_MUTE_REQ = power_state_and_mute[`BIT_SOFT_MUTE];
  assign cmd_state = power_state_and_mute[`PS_MSB:`PS_LSB];

  // dsp held while the hold bit is set or a full reset is under way
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DSP_HOLD_IN_RESET <= 1'b1;
    end else begin
      DSP_HOLD_IN_RESET <= power_state_and_mute[`BIT_DSP_HOLD] | full_reset_req;
    end
  end

  // volume goes to zero when muted or when play is being left
  assign target_mute = power_state_and_mute[`BIT_SOFT_MUTE] | (cmd_state != `PS_PLAY);

  // last count of the ramp step timer
  localparam [15:0] RAMP_LAST = RAMP_STEP_CYCLES[15:0] - 16'h0001;
  assign ramp_tick = (ramp_cnt == RAMP_LAST);

  // step timer for the volume ramp
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ramp_cnt <= 16'h0000;
    end else if (ramp_tick) begin
      ramp_cnt <= 16'h0000;
    end else begin
      ramp_cnt <= ramp_cnt + 16'h0001;
    end
  end

  // one-step-per-tick ramp between zero and full scale; a full reset drops it straight to zero
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      VOLUME_SCALE <= `VOL_ZERO;
    end else if (full_reset_req) begin
      VOLUME_SCALE <= `VOL_ZERO;
    end else if (ramp_tick) begin
      if (target_mute && (VOLUME_SCALE != `VOL_ZERO)) begin
        VOLUME_SCALE <= VOLUME_SCALE - 8'h01;
      end else if (!target_mute && (POWER_STATE == `PS_PLAY) && (VOLUME_SCALE != `VOL_FULL)) begin
        VOLUME_SCALE <= VOLUME_SCALE + 8'h01;
      end
    end
  end

  // applied power state; leaving play waits for the ramp to reach zero, except on a full reset, which forces deep sleep at once
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      POWER_STATE <= `PS_DEEP_SLEEP;
    end else if (full_reset_req) begin
      POWER_STATE <= `PS_DEEP_SLEEP;
    end else if (POWER_STATE != cmd_state) begin
      if ((POWER_STATE != `PS_PLAY) || (VOLUME_SCALE == `VOL_ZERO)) begin
        POWER_STATE <= cmd_state;
      end
    end
  end

endmodule

`default_nettype wire

/* File: test/amp_core_control_regs_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_core_control_regs_checker #(
  parameter int RAMP_STEP_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] SWITCHING_FREQ_SELECT,
  input wire logic [1:0] MODULATION_SCHEME,
  input wire logic DSP_HOLD_IN_RESET,
  input wire logic SOFT_MUTE_REQ,
  input wire logic [1:0] POWER_STATE,
  input wire logic [7:0] VOLUME_SCALE,
  input wire logic DIGITAL_CORE_RESET,
  input wire logic COEF_RAM_CLEAR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // full reset pulse pair, gone one cycle later
  sequence s_core_pulse;
    COEF_RAM_CLEAR ##1 !DIGITAL_CORE_RESET && !COEF_RAM_CLEAR;
  endsequence
  // what the core looks like once the full reset lands
  sequence s_core_quiet;
    VOLUME_SCALE == 8'h00 && POWER_STATE == 2'h0 && DSP_HOLD_IN_RESET;
  endsequence
  chk_core_pulse_pair: assert property (DIGITAL_CORE_RESET |-> s_core_pulse)
    else $error("core reset pulse malformed");
  chk_core_state_quiet: assert property (DIGITAL_CORE_RESET |-> ##[0:1] s_core_quiet)
    else $error("core not quiet after full reset");
  chk_freq_code_legal: assert property (SWITCHING_FREQ_SELECT < 3'h6)
    else $error("reserved switching code applied");
  chk_mod_code_legal: assert property (MODULATION_SCHEME != 2'h3)
    else $error("reserved modulation code applied");
  chk_vol_single_step: assert property ($changed(VOLUME_SCALE) && !DIGITAL_CORE_RESET
      && !$past(DIGITAL_CORE_RESET) |-> (VOLUME_SCALE - $past(VOLUME_SCALE) == 8'h01)
      || ($past(VOLUME_SCALE) - VOLUME_SCALE == 8'h01))
    else $error("volume jumped by more than one step");
  chk_mute_no_rise: assert property (SOFT_MUTE_REQ && $past(SOFT_MUTE_REQ)
      |-> VOLUME_SCALE <= $past(VOLUME_SCALE))
    else $error("volume rose while muted");
  chk_vol_up_play: assert property (VOLUME_SCALE > $past(VOLUME_SCALE)
      |-> $past(POWER_STATE) == 2'h3 && !$past(SOFT_MUTE_REQ))
    else $error("volume rose outside unmuted play");
  chk_play_exit_silent: assert property ($past(POWER_STATE) == 2'h3 && POWER_STATE != 2'h3
      && !DIGITAL_CORE_RESET && !$past(DIGITAL_CORE_RESET) |-> $past(VOLUME_SCALE) == 8'h00)
    else $error("left play with volume up");
endmodule
bind amp_core_control_regs amp_core_control_regs_checker #(.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) i_chk (
  .CLK(CLK),
  .RST_N(RST_N),
  .SWITCHING_FREQ_SELECT(SWITCHING_FREQ_SELECT),
  .MODULATION_SCHEME(MODULATION_SCHEME),
  .DSP_HOLD_IN_RESET(DSP_HOLD_IN_RESET),
  .SOFT_MUTE_REQ(SOFT_MUTE_REQ),
  .POWER_STATE(POWER_STATE),
  .VOLUME_SCALE(VOLUME_SCALE),
  .DIGITAL_CORE_RESET(DIGITAL_CORE_RESET),
  .COEF_RAM_CLEAR(COEF_RAM_CLEAR)
);
`default_nettype wire

/* File: test/i2c_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h58
) (
  input wire logic clk,
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  int n_nack;
  // bus idle, both lines released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    n_nack = 0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start or repeated start, clock left low
  task automatic start_cond;
    sda <= 1'b1;
    gap(4);
    scl <= 1'b1;
    gap(5);
    sda <= 1'b0;
    gap(5);
    scl <= 1'b0;
    gap(4);
  endtask
  task automatic stop_cond;
    sda <= 1'b0;
    gap(4);
    scl <= 1'b1;
    gap(5);
    sda <= 1'b1;
    gap(5);
  endtask
  // eight data bits then the acknowledge slot, data held 3 clocks past each fall
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda <= tx[i];
      gap(4);
      scl <= 1'b1;
      gap(5);
      rx[i] = sda_line;
      scl <= 1'b0;
      gap(3);
    end
  endtask
  task automatic send(input logic [7:0] b);
    logic [8:0] rx;
    xfer({b, 1'b1}, rx);
    if (rx[0] !== 1'b0) n_nack++;
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data);
    start_cond;
    send({DEV_ADDR, 1'b0});
    send(ofs);
    send(data);
    stop_cond;
  endtask
  // pointer set, repeated start, one byte then nack
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data);
    logic [8:0] rx;
    start_cond;
    send({DEV_ADDR, 1'b0});
    send(ofs);
    start_cond;
    send({DEV_ADDR, 1'b1});
    xfer(9'h1ff, rx);
    data = rx[8:1];
    stop_cond;
  endtask
  // page zero, book zero, page zero again
  task automatic select_core_page;
    write_reg(8'h00, 8'h00);
    write_reg(8'h7f, 8'h00);
    write_reg(8'h00, 8'h00);
  endtask
endmodule
`default_nettype wire

/* File: test/amp_core_control_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_core_control_regs_tb;
  localparam int RAMP = 1;
  localparam int LIMIT = 60000;
  logic clk, rst_n, scl, host_sda, sda_out, sda_oe, parallel_bridge_tied_load, hold, mute, core_rst, ram_clr;
  logic [2:0] fsw;
  logic [1:0] modsel, pstate;
  logic [7:0] vol, rd, v, exp_cfg;
  wire sda_wire;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n_pulse = 0;
  int n_clear = 0;
  // open-drain wire with pull-up
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & host_sda;
  amp_core_control_regs #(.RAMP_STEP_CYCLES(RAMP)) i_dut (
    .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .SWITCHING_FREQ_SELECT(fsw), .PARALLEL_BRIDGE_SELECT(parallel_bridge_tied_load), .MODULATION_SCHEME(modsel),
    .DSP_HOLD_IN_RESET(hold), .SOFT_MUTE_REQ(mute), .POWER_STATE(pstate), .VOLUME_SCALE(vol),
    .DIGITAL_CORE_RESET(core_rst), .COEF_RAM_CLEAR(ram_clr));
  i2c_host_model i_host (.clk(clk), .scl(scl), .sda(host_sda), .sda_line(sda_wire));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cycle watchdog and core pulse count
  always @(posedge clk) begin
    cycles++;
    if (core_rst === 1'b1) n_pulse++;
    if (ram_clr === 1'b1) n_clear++;
    if (cycles == LIMIT) begin
      n_errors++;
      test_done;
    end
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch reg at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch pin at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // reserved codes keep the old field, reserved bits drop
  function automatic logic [7:0] cfg_next(input logic [7:0] prev, input logic [7:0] w);
    logic [2:0] f;
    logic [1:0] m;
    f = (w[6:4] >= 3'h6) ? prev[6:4] : w[6:4];
    m = (w[1:0] == 2'h3) ? prev[1:0] : w[1:0];
    return {1'b0, f, 1'b0, w[2], m};
  endfunction
  function automatic logic [7:0] cfg_pins();
    return {1'b0, fsw, 1'b0, parallel_bridge_tied_load, modsel};
  endfunction
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    exp_cfg = 8'h00;
    void'($urandom(66));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_pin({7'h00, hold}, 8'h01);
    i_host.select_core_page;
    i_host.read_reg(8'h01, rd);
    chk_reg(rd, 8'h00);
    i_host.read_reg(8'h03, rd);
    chk_reg(rd, 8'h10);
    // unmapped offset is only ever read
    i_host.read_reg(8'h40, rd);
    chk_reg(rd, 8'h00);
    // every frequency and modulation code, reserved ones too
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[6:4] = 3'(i);
      v[1:0] = 2'(i);
      exp_cfg = cfg_next(exp_cfg, v);
      i_host.write_reg(8'h02, v);
      chk_pin(cfg_pins(), exp_cfg);
      i_host.read_reg(8'h02, rd);
      chk_reg(rd, exp_cfg);
    end
    // each power state, muted so the volume stays at zero
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      v[3] = 1'b1;
      v[1:0] = 2'(k);
      i_host.write_reg(8'h03, v);
      chk_pin({3'h0, hold, mute, 1'b0, pstate}, v & 8'h1b);
      i_host.read_reg(8'h03, rd);
      chk_reg(rd, v & 8'h1b);
    end
    // clock has run since time zero before the dsp is released
    i_host.write_reg(8'h03, 8'h03);
    chk_pin({7'h00, hold}, 8'h00);
    repeat (300 * RAMP) @(posedge clk);
    chk_pin(vol, 8'hff);
    i_host.write_reg(8'h03, 8'h0b);
    repeat (300 * RAMP) @(posedge clk);
    chk_pin(vol, 8'h00);
    chk_pin({6'h00, pstate}, 8'h03);
    i_host.write_reg(8'h03, 8'h03);
    repeat (300 * RAMP) @(posedge clk);
    i_host.write_reg(8'h03, 8'h02);
    chk_pin({6'h00, pstate}, 8'h03);
    repeat (300 * RAMP) @(posedge clk);
    chk_pin({6'h00, pstate}, 8'h02);
    // register reset leaves the core pulse quiet
    i_host.write_reg(8'h02, 8'h35);
    i_host.write_reg(8'h01, 8'h01);
    chk_pin(cfg_pins(), 8'h00);
    i_host.read_reg(8'h01, rd);
    chk_reg(rd, 8'h00);
    i_host.read_reg(8'h03, rd);
    chk_reg(rd, 8'h10);
    chk_pin(8'(n_pulse), 8'h00);
    chk_pin(8'(n_clear), 8'h00);
    // full reset while playing with the volume already ramped to full scale
    i_host.write_reg(8'h02, 8'h35);
    i_host.write_reg(8'h03, 8'h03);
    repeat (40 * RAMP) @(posedge clk);
    i_host.write_reg(8'h01, 8'h10);
    chk_pin(8'(n_pulse), 8'h01);
    chk_pin(8'(n_clear), 8'h01);
    chk_pin(vol, 8'h00);
    chk_pin({5'h00, hold, pstate}, 8'h04);
    chk_pin(cfg_pins(), 8'h00);
    i_host.read_reg(8'h03, rd);
    chk_reg(rd, 8'h10);
    // reset in mid-run while the bus is idle
    i_host.write_reg(8'h02, 8'h35);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_pin(cfg_pins(), 8'h00);
    chk_pin({5'h00, hold, pstate}, 8'h04);
    i_host.read_reg(8'h02, rd);
    chk_reg(rd, 8'h00);
    chk_pin(8'(i_host.n_nack), 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
